//--- hdl/vector_reg_width_alias_caps.sv
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "vrf_defs.svh"
module vector_reg_width_alias_caps #(
  parameter bit HAS_FOUND = 1'b1,
  parameter bit HAS_CD    = 1'b1,
  parameter bit HAS_DQ    = 1'b1,
  parameter bit HAS_BW    = 1'b1,
  parameter bit HAS_SHORT = 1'b1
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // APB slave
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Instruction request
  input  wire logic              ins_valid,
  input  vrf_pkg::prefix_e       ins_prefix,
  input  vrf_pkg::vlen_e         ins_len,
  input  vrf_pkg::esize_e        ins_esize,
  input  vrf_pkg::group_e        ins_group,
  input  wire logic              ins_short256_only,
  input  wire logic [4:0]        ins_dst,
  input  wire logic              ins_dst_wr,
  input  wire logic [4:0]        ins_src,
  input  wire logic              ins_src_rd,
  input  wire logic [511:0]      ins_wdata,
  input  wire logic              ins_bcast,
  input  wire logic [2:0]        ins_mask_sel,
  input  wire logic              ins_zeroing,
  input  wire logic [63:0]       ins_exc,
  input  wire logic              ins_rr_form,
  input  wire logic              ins_scalar,
  input  wire logic              ins_rnd_ovr,
  input  wire logic [1:0]        ins_rnd_mode,
  input  wire logic [7:0]        ins_disp8,
  input  wire logic [2:0]        ins_disp_scale,
  // Instruction results
  output logic      [511:0]      ins_rdata,
  output logic                   ins_rvalid,
  output logic                   ins_ud,
  output logic      [1:0]        rnd_mode,
  output logic      [31:0]       disp,
  output logic      [63:0]       elem_en,
  // Mask register operand port
  input  wire logic              mk_we,
  input  wire logic [2:0]        mk_idx,
  input  wire logic [63:0]       mk_wdata,
  input  wire logic [2:0]        mk_ridx,
  output logic      [63:0]       mk_rdata
);
  import vrf_pkg::*;

  // ----------------------------------------------------------------
  // Capabilities
  // ----------------------------------------------------------------
  wire logic [31:0] cap_word = (32'(HAS_FOUND) << `CAP_FOUND_BIT)
                             | (32'(HAS_DQ) << `CAP_DQ_BIT)
                             | (32'(HAS_CD) << `CAP_CD_BIT)
                             | (32'(HAS_BW) << `CAP_BW_BIT)
                             | (32'(HAS_SHORT) << `CAP_SHORT_BIT);

  // ----------------------------------------------------------------
  // Decode and fault checks
  // ----------------------------------------------------------------
  wire logic is_legacy = (ins_prefix == PFX_LEGACY);
  wire logic is_wide   = (ins_prefix == PFX_WIDE);
  wire logic grp_flag  = (ins_group == GRP_FOUND) ? HAS_FOUND :
                         (ins_group == GRP_CD)    ? HAS_CD :
                         (ins_group == GRP_DQ)    ? HAS_DQ : HAS_BW;
  wire logic short_ok  = HAS_FOUND & grp_flag & HAS_SHORT;
  wire logic ud_len    = is_wide & (ins_len != VL512) & ~short_ok;
  wire logic ud_256    = is_wide & ins_short256_only
                       & (ins_len == VL128);
  wire logic ud_reg    = ~is_wide & ins_dst[4];
  wire logic ud_vl     = ~is_wide & ~is_legacy & (ins_len == VL512);
  wire logic ud_pfx    = (ins_prefix != PFX_LEGACY) & (ins_prefix != PFX_SHORT) & ~is_wide;
  wire logic ud_now    = ins_valid & (ud_len | ud_256 | ud_reg | ud_vl | ud_pfx);

  // Legacy class always works on the low 128 bits only
  wire vlen_e   eff_len   = is_legacy ? VL128 : ins_len;
  wire logic [6:0] len_bytes = 7'(`LOW_BYTES) << eff_len;
  wire logic [1:0] es     = ins_esize;
  wire logic [2:0] pred_sel = is_wide ? ins_mask_sel : 3'h0;
  wire logic [6:0] elem_cnt = len_bytes >> es;

  // ----------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------
  logic [63:0] mask_q [`NUM_MASK];
  logic [63:0] mk_rdata_q;
  wire logic [63:0] pred = mask_q[pred_sel];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < `NUM_MASK; i++) begin
        mask_q[i] <= '0;
      end
      mk_rdata_q <= '0;
    end else begin
      if (mk_we) begin
        mask_q[mk_idx] <= mk_wdata;
      end
      mk_rdata_q <= mask_q[mk_ridx];
    end
  end

  // ----------------------------------------------------------------
  // Per-element activity
  // ----------------------------------------------------------------
  logic [63:0] elem_act;
  for (genvar e = 0; e < `MASK_W; e++) begin : g_elem
    assign elem_act[e] = (7'(e) < elem_cnt)
                       & ((pred_sel == 3'h0) | pred[e]);
  end

  // ----------------------------------------------------------------
  // Per-byte write enables and data
  // ----------------------------------------------------------------
  logic [63:0]  ins_be;
  logic [511:0] ins_wd;
  logic [511:0] view_mask;
  for (genvar b = 0; b < `VL_BYTES; b++) begin : g_byte
    wire logic [5:0] bsub  = 6'(b) & ((6'h01 << es) - 6'h01);
    wire logic [5:0] bsrc  = ins_bcast ? bsub : 6'(b);
    wire logic       inl   = (7'(b) < len_bytes);
    wire logic       act   = elem_act[6'(b) >> es];
    // Inside the length: merge keeps, wide-prefix zeroing clears; above it:
    // prefixed forms clear, the legacy class does not touch
    assign ins_be[b] = inl ? (act | (ins_zeroing & is_wide))
                           : ~is_legacy;
    assign ins_wd[b*8 +: 8] = (inl & act) ? ins_wdata[bsrc*8 +: 8]
                                          : 8'h00;
    assign view_mask[b*8 +: 8] = inl ? 8'hFF : 8'h00;
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] sel_q;
  logic        st_exc_q;
  logic        st_ud_q;
  wire logic [4:0] sel_idx  = sel_q[`SEL_IDX_LSB +: 5];
  wire logic [3:0] sel_word = sel_q[`SEL_WORD_LSB +: 4];

  wire logic hit_cap  = (paddr == `OFS_CAP);
  wire logic hit_ctrl = (paddr == `OFS_CTRL);
  wire logic hit_stat = (paddr == `OFS_STATUS);
  wire logic hit_sel  = (paddr == `OFS_SEL);
  wire logic hit_data = (paddr == `OFS_DATA);
  wire logic hit_any  = hit_cap | hit_ctrl | hit_stat | hit_sel | hit_data;

  wire logic [31:0] stat_word = (32'(st_ud_q) << `STAT_UD_BIT)
                              | (32'(st_exc_q) << `STAT_EXC_BIT);
  wire logic [31:0] reg_rd = hit_cap  ? cap_word :
                             hit_ctrl ? ctrl_q :
                             hit_stat ? stat_word :
                             hit_sel  ? sel_q : 32'h0000_0000;

  // ----------------------------------------------------------------
  // APB access control
  // ----------------------------------------------------------------
  apb_st_e     ap_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  wire logic acc      = psel & penable & ~pready_q;
  wire logic acc_idle = acc & (ap_q == AP_IDLE);
  wire logic reg_wr   = acc_idle & pwrite & hit_any & ~hit_data;
  // Data window yields to a same-cycle instruction
  wire logic apb_rd_go = acc_idle & hit_data & ~pwrite & ~ins_valid;
  wire logic apb_wr_go = acc_idle & hit_data & pwrite & ~ins_valid;
  wire logic stat_w1c  = reg_wr & hit_stat;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  wire logic [63:0] ins_wbe  = ins_valid & ins_dst_wr & ~ud_now ? ins_be : 64'h0;
  wire logic        mem_we   = (|ins_wbe) | apb_wr_go;
  wire logic [4:0]  mem_wa   = ins_valid ? ins_dst : sel_idx;
  wire logic [63:0] apb_be   = 64'hF << {sel_word, 2'b00};
  wire logic [63:0] mem_be   = ins_valid ? ins_wbe : apb_be;
  wire logic [511:0] mem_wd  = ins_valid ? ins_wd : {16{pwdata}};
  wire logic        ins_re   = ins_valid & ins_src_rd & ~ud_now;
  wire logic        mem_re   = ins_re | apb_rd_go;
  wire logic [4:0]  mem_ra   = ins_valid ? ins_src : sel_idx;
  logic [511:0]     mem_rd;

  // One storage for all three views
  vrf_mem #(
    .DEPTH (`NUM_VREG),
    .BYTES (`VL_BYTES),
    .AW    (5)
  ) u_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .we      (mem_we),
    .waddr   (mem_wa),
    .wbe     (mem_be),
    .wdata   (mem_wd),
    .re      (mem_re),
    .raddr   (mem_ra),
    .rdata_q (mem_rd)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ap_q      <= AP_IDLE;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      case (ap_q)
        AP_IDLE: begin
          if (apb_rd_go) begin
            ap_q <= AP_READ;
          end else if (acc & ~hit_data) begin
            pready_q  <= 1'b1;
            pslverr_q <= ~hit_any;
            prdata_q  <= reg_rd;
          end else if (apb_wr_go) begin
            pready_q <= 1'b1;
          end
        end
        AP_READ: begin
          ap_q     <= AP_IDLE;
          pready_q <= 1'b1;
          prdata_q <= mem_rd[sel_word*32 +: 32];
        end
        default: begin
          ap_q <= AP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= `CTRL_RST;
      sel_q  <= `SEL_RST;
    end else if (reg_wr) begin
      if (hit_ctrl) begin
        ctrl_q <= {30'h0, pwdata[`CTRL_RND_LSB +: 2]};
      end
      if (hit_sel) begin
        sel_q <= {20'h0, pwdata[11:8], 3'h0, pwdata[4:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky status; a new event beats a same-cycle clear
  // ----------------------------------------------------------------
  wire logic exc_set = ins_valid & ~ud_now & |(ins_exc & elem_act);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_exc_q <= 1'b0;
      st_ud_q  <= 1'b0;
    end else begin
      st_exc_q <= exc_set | (st_exc_q & ~(stat_w1c & pwdata[`STAT_EXC_BIT]));
      st_ud_q  <= ud_now | (st_ud_q & ~(stat_w1c & pwdata[`STAT_UD_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // Instruction results
  // ----------------------------------------------------------------
  logic [511:0] ins_rdata_q;
  logic [511:0] view_q;
  logic         rd_pend_q;
  logic         ins_rvalid_q;
  logic         ins_ud_q;
  logic [1:0]   rnd_q;
  logic [31:0]  disp_q;
  logic [63:0]  elem_en_q;
  wire logic    rnd_sel = ins_rr_form & ins_rnd_ovr & (ins_scalar | (ins_len == VL512));
  wire logic [31:0] disp_ext = {{24{ins_disp8[7]}}, ins_disp8};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ins_rdata_q  <= '0;
      view_q       <= '0;
      rd_pend_q    <= 1'b0;
      ins_rvalid_q <= 1'b0;
      ins_ud_q     <= 1'b0;
      rnd_q        <= 2'h0;
      disp_q       <= '0;
      elem_en_q    <= '0;
    end else begin
      rd_pend_q    <= ins_re;
      view_q       <= view_mask;
      ins_rvalid_q <= rd_pend_q;
      if (rd_pend_q) begin
        ins_rdata_q <= mem_rd & view_q;
      end
      ins_ud_q <= ud_now;
      if (ins_valid) begin
        rnd_q     <= rnd_sel ? ins_rnd_mode : ctrl_q[`CTRL_RND_LSB +: 2];
        disp_q    <= disp_ext << ins_disp_scale;
        elem_en_q <= ud_now ? 64'h0 : elem_act;
      end
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign ins_rdata  = ins_rdata_q;
  assign ins_rvalid = ins_rvalid_q;
  assign ins_ud     = ins_ud_q;
  assign rnd_mode   = rnd_q;
  assign disp       = disp_q;
  assign elem_en    = elem_en_q;
  assign mk_rdata   = mk_rdata_q;
endmodule

//--- hdl/vrf_defs.svh
`ifndef VRF_DEFS_SVH
`define VRF_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_CAP        12'h000
`define OFS_CTRL       12'h004
`define OFS_STATUS     12'h008
`define OFS_SEL        12'h00C
`define OFS_DATA       12'h010
// ----------------------------------------------------------------
// Capability word bit positions
// ----------------------------------------------------------------
`define CAP_FOUND_BIT  16
`define CAP_DQ_BIT     17
`define CAP_CD_BIT     28
`define CAP_BW_BIT     30
`define CAP_SHORT_BIT  31
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CTRL_RND_LSB   0
`define STAT_EXC_BIT   0
`define STAT_UD_BIT    1
`define SEL_IDX_LSB    0
`define SEL_WORD_LSB   8
`define CTRL_RST       32'h0000_0000
`define SEL_RST        32'h0000_0000
// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define MAX_VL         512
`define NUM_VREG       32
`define NUM_MASK       8
`define MASK_W         64
`define VL_BYTES       64
`define LOW_BYTES      16
`endif

//--- hdl/vrf_pkg.sv
package vrf_pkg;
  typedef enum logic [1:0] {
    PFX_LEGACY = 2'b00,
    PFX_SHORT  = 2'b01,
    PFX_WIDE   = 2'b10
  } prefix_e;
  typedef enum logic [1:0] {
    VL128 = 2'b00,
    VL256 = 2'b01,
    VL512 = 2'b10
  } vlen_e;
  typedef enum logic [1:0] {
    ES8  = 2'b00,
    ES16 = 2'b01,
    ES32 = 2'b10,
    ES64 = 2'b11
  } esize_e;
  typedef enum logic [1:0] {
    GRP_FOUND = 2'b00,
    GRP_CD    = 2'b01,
    GRP_DQ    = 2'b10,
    GRP_BW    = 2'b11
  } group_e;
  typedef enum logic {
    AP_IDLE = 1'b0,
    AP_READ = 1'b1
  } apb_st_e;
endpackage

//--- hdl/vrf_mem.sv
`timescale 1ns/1ns
module vrf_mem #(
  parameter int DEPTH = 32,
  parameter int BYTES = 64,
  parameter int AW    = 5
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Write port with byte enables
  input  wire logic               we,
  input  wire logic [AW-1:0]      waddr,
  input  wire logic [BYTES-1:0]   wbe,
  input  wire logic [BYTES*8-1:0] wdata,
  // Registered read port
  input  wire logic               re,
  input  wire logic [AW-1:0]      raddr,
  output logic      [BYTES*8-1:0] rdata_q
);
  wire logic [BYTES*8-1:0] rd_w;

  // One storage array per byte lane, so each lane has a single writer
  for (genvar b = 0; b < BYTES; b++) begin : g_byte
    logic [7:0] lane [DEPTH];
    always_ff @(posedge clk) begin
      if (we && wbe[b]) begin
        lane[waddr] <= wdata[b*8 +: 8];
      end
    end
    assign rd_w[b*8 +: 8] = lane[raddr];
  end

  // Read during write returns the old contents
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else if (re) begin
      rdata_q <= rd_w;
    end
  end
endmodule

//--- tb/vector_reg_width_alias_caps_properties.sv
`timescale 1ns/1ns
module vrf_properties (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_b,
  // APB
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  // Instruction request
  input wire logic         ins_valid,
  input vrf_pkg::prefix_e  ins_prefix,
  input vrf_pkg::vlen_e    ins_len,
  input vrf_pkg::esize_e   ins_esize,
  input wire logic         ins_short256_only,
  input wire logic         ins_src_rd,
  input wire logic [2:0]   ins_mask_sel,
  input wire logic         ins_rr_form,
  input wire logic         ins_rnd_ovr,
  input wire logic [1:0]   ins_rnd_mode,
  input wire logic [7:0]   ins_disp8,
  input wire logic [2:0]   ins_disp_scale,
  // Instruction results
  input wire logic         ins_rvalid,
  input wire logic         ins_ud,
  input wire logic [1:0]   rnd_mode,
  input wire logic [31:0]  disp,
  input wire logic [63:0]  elem_en,
  // Mask port
  input wire logic         mk_we,
  input wire logic [2:0]   mk_idx,
  input wire logic [63:0]  mk_wdata,
  input wire logic [2:0]   mk_ridx,
  input wire logic [63:0]  mk_rdata
);
  import vrf_pkg::*;
  logic [31:0] disp_x;
  assign disp_x = {{24{ins_disp8[7]}}, ins_disp8} << ins_disp_scale;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence wide512_s;
    ins_valid && ins_prefix == PFX_WIDE && ins_len == VL512;
  endsequence
  sequence read_ok_s;
    ins_valid && ins_src_rd ##1 !ins_ud;
  endsequence
  cap_word_a: assert property (
    psel && penable && !pwrite && paddr == 12'h000 && pready |-> prdata == 32'hD003_0000)
    else $error("capability word wrong");
  bad_prefix_a: assert property (
    ins_valid && ins_prefix == 2'b11 |=> ins_ud) else $error("bad prefix not refused");
  no_short128_a: assert property (
    ins_valid && ins_prefix == PFX_WIDE && ins_len == VL128 && ins_short256_only |=> ins_ud)
    else $error("128 form of 256-only op accepted");
  wide_accept_a: assert property (
    wide512_s |=> !ins_ud) else $error("wide 512 op refused");
  fault_quiet_a: assert property (
    ins_ud |-> elem_en == 64'h0 ##1 !ins_rvalid) else $error("fault left effects");
  read_lat_a: assert property (
    read_ok_s |=> ins_rvalid) else $error("read result missing");
  rnd_override_a: assert property (
    wide512_s and (ins_rr_form && ins_rnd_ovr) |=> rnd_mode == $past(ins_rnd_mode))
    else $error("rounding override ignored");
  disp_scale_a: assert property (
    ins_valid ##1 !ins_ud |-> disp == $past(disp_x)) else $error("displacement wrong");
  low_mask_a: assert property (
    wide512_s and (ins_esize == ES64 && ins_mask_sel == 3'h0) |=> elem_en == 64'hFF)
    else $error("element enables wrong");
  mask_read_a: assert property (
    mk_we ##1 (!mk_we && mk_ridx == $past(mk_idx)) |=> mk_rdata == $past(mk_wdata, 2))
    else $error("mask readback wrong");
endmodule

//--- tb/vector_reg_width_alias_caps_tb.sv
`timescale 1ns/1ns
module vector_reg_width_alias_caps_tb;
  import vrf_pkg::*;
  logic         clk, rst_b, psel, penable, pwrite, pready, pslverr, vd;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, disp, dv;
  prefix_e      ins_prefix;
  vlen_e        ins_len;
  esize_e       ins_esize;
  group_e       ins_group;
  logic         ins_valid, ins_short256_only, ins_dst_wr, ins_src_rd, ins_bcast;
  logic         ins_zeroing, ins_rr_form, ins_scalar, ins_rnd_ovr, ins_rvalid, ins_ud, mk_we;
  logic [4:0]   ins_dst, ins_src, id;
  logic [3:0]   wd;
  logic [511:0] ins_wdata, ins_rdata;
  logic [2:0]   ins_mask_sel, ins_disp_scale, mk_idx, mk_ridx;
  logic [63:0]  ins_exc, elem_en, mk_wdata, mk_rdata;
  logic [1:0]   ins_rnd_mode, rnd_mode, stat;
  logic [7:0]   ins_disp8;
  logic [511:0] vref [32];
  logic [63:0]  mref [8];
  logic [33:0]  aq [$];
  logic [33:0]  ae;
  logic [64:0]  uq [$];
  logic [511:0] rq [$];
  int           mismatches, tests_run, cycles;

  vector_reg_width_alias_caps i_vector_reg_width_alias_caps (
    .clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .ins_valid, .ins_prefix, .ins_len, .ins_esize, .ins_group, .ins_short256_only,
    .ins_dst, .ins_dst_wr, .ins_src, .ins_src_rd, .ins_wdata, .ins_bcast, .ins_mask_sel,
    .ins_zeroing, .ins_exc, .ins_rr_form, .ins_scalar, .ins_rnd_ovr, .ins_rnd_mode,
    .ins_disp8, .ins_disp_scale, .ins_rdata, .ins_rvalid, .ins_ud, .rnd_mode, .disp,
    .elem_en, .mk_we, .mk_idx, .mk_wdata, .mk_ridx, .mk_rdata);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------
  // Checking and closing
  // ------------------------------------------------
  task automatic chk(input logic [511:0] got, input logic [511:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (pready === 1'b1) begin
      ae = aq.size() ? aq.pop_front() : 'x;
      chk(512'({pslverr, ae[33] ? prdata : 32'h0}), 512'(ae[32:0]));
    end
    if (ins_rvalid === 1'b1) chk(ins_rdata, rq.size() ? rq.pop_front() : 'x);
    if (vd) chk(512'({ins_ud, elem_en}), uq.size() ? 512'(uq.pop_front()) : 'x);
    vd = (ins_valid === 1'b1) && (rst_b === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // ------------------------------------------------
  // Drivers with reference model
  // ------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] ex);
    aq.push_back({!w, ex[32], w ? 32'h0 : ex[31:0]});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic mask(input logic [2:0] i, input logic [63:0] v);
    @(posedge clk);
    mk_we <= 1'b1;
    mk_idx <= i;
    mk_ridx <= i;
    mk_wdata <= v;
    mref[i] = v;
    @(posedge clk);
    mk_we <= 1'b0;
  endtask

  task automatic ins(input logic [1:0] p, input logic [1:0] l, input logic [1:0] es,
                     input logic [4:0] d, input logic [4:0] s, input logic [2:0] m,
                     input logic sh, input logic wr, input logic rdx);
    logic         f, bc, zr;
    logic [63:0]  act, exc;
    logic [511:0] o, r, w;
    int           lb;
    for (int k = 0; k < 16; k++) w[32*k+:32] = $urandom;
    bc = 1'($urandom);
    zr = 1'($urandom);
    exc = {$urandom, $urandom};
    lb = (p == 2'd0) ? 16 : 16 << l;
    f = p == 2'd3 || (p == 2'd2 && l == 2'd0 && sh) || (p != 2'd2 && d[4])
        || (p == 2'd1 && l == 2'd2);
    o = vref[d];
    r = vref[s];
    for (int b = 0; b < 64; b++) begin
      act[b] = b < (lb >> es) && (p != 2'd2 || m == 3'h0 || mref[m][b]);
      if (b >= lb) begin
        r[8*b+:8] = 8'h00;
        if (p != 2'd0) o[8*b+:8] = 8'h00;
      end else if (act[b>>es]) o[8*b+:8] = bc ? w[8*(b%(1<<es))+:8] : w[8*b+:8];
      else if (zr && p == 2'd2) o[8*b+:8] = 8'h00;
    end
    @(posedge clk);
    ins_valid <= 1'b1;
    ins_prefix <= prefix_e'(p);
    ins_len <= vlen_e'(l);
    ins_esize <= esize_e'(es);
    ins_group <= group_e'(2'($urandom));
    {ins_dst, ins_dst_wr, ins_src, ins_src_rd, ins_mask_sel, ins_short256_only} <=
      {d, wr, s, rdx, m, sh};
    {ins_wdata, ins_bcast, ins_zeroing, ins_exc} <= {w, bc, zr, exc};
    {ins_rr_form, ins_scalar, ins_rnd_ovr, ins_rnd_mode, ins_disp8, ins_disp_scale} <=
      16'($urandom);
    uq.push_back({f, f ? 64'h0 : act});
    if (!f && rdx) rq.push_back(r);
    if (f) stat[1] = 1'b1;
    else begin
      stat[0] = stat[0] | (|(exc & act));
      if (wr) vref[d] = o;
    end
  endtask

  task automatic idle();
    @(posedge clk);
    ins_valid <= 1'b0;
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, ins_valid, ins_short256_only} = '0;
    {ins_dst, ins_dst_wr, ins_src, ins_src_rd, ins_wdata, ins_bcast, ins_mask_sel} = '0;
    {ins_zeroing, ins_exc, ins_rr_form, ins_scalar, ins_rnd_ovr, ins_rnd_mode} = '0;
    {ins_disp8, ins_disp_scale, mk_we, mk_idx, mk_wdata, mk_ridx, stat} = '0;
    {mismatches, tests_run, cycles, vd} = '0;
    ins_prefix = PFX_LEGACY;
    ins_len = VL128;
    ins_esize = ES8;
    ins_group = GRP_FOUND;
    void'($urandom(32'h29CF0F42));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, 12'h000, 32'h0, {1'b0, 32'hD003_0000});
    apb(1'b1, 12'h004, 32'h3, 33'h0);
    apb(1'b0, 12'h004, 32'h0, 33'h3);
    apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 8; i++) mask(3'(i), {$urandom, $urandom});
    for (int i = 0; i < 32; i++) ins(2'd2, 2'd2, 2'($urandom), 5'(i), 5'(i), 3'h0, 1'b0, 1'b1, 1'b0);
    ins(2'd3, 2'd0, 2'd0, 5'd1, 5'd1, 3'h0, 1'b0, 1'b1, 1'b1);
    ins(2'd2, 2'd0, 2'd0, 5'd2, 5'd2, 3'h1, 1'b1, 1'b1, 1'b1);
    ins(2'd2, 2'd1, 2'd0, 5'd2, 5'd2, 3'h1, 1'b1, 1'b1, 1'b1);
    ins(2'd2, 2'd2, 2'd3, 5'd4, 5'd4, 3'h0, 1'b0, 1'b1, 1'b1);
    ins(2'd0, 2'd0, 2'd0, 5'd17, 5'd3, 3'h0, 1'b0, 1'b1, 1'b1);
    ins(2'd0, 2'd2, 2'd0, 5'd5, 5'd5, 3'h0, 1'b0, 1'b1, 1'b1);
    ins(2'd2, 2'd2, 2'd0, 5'd6, 5'd5, 3'h0, 1'b0, 1'b0, 1'b1);
    ins(2'd1, 2'd0, 2'd1, 5'd7, 5'd7, 3'h0, 1'b0, 1'b1, 1'b1);
    ins(2'd1, 2'd1, 2'd2, 5'd8, 5'd7, 3'h0, 1'b0, 1'b1, 1'b1);
    ins(2'd2, 2'd2, 2'd0, 5'd9, 5'd8, 3'h0, 1'b0, 1'b0, 1'b1);
    idle();
    for (int i = 0; i < 8; i++) begin
      id = 5'($urandom);
      wd = (i == 0) ? 4'hF : 4'($urandom);
      dv = $urandom;
      apb(1'b1, 12'h00C, {20'h0, wd, 3'h0, id}, 33'h0);
      apb(1'b1, 12'h010, dv, 33'h0);
      vref[id][32*wd+:32] = dv;
      apb(1'b0, 12'h010, 32'h0, {1'b0, dv});
    end
    for (int i = 0; i < 400; i++)
      ins(2'($urandom), 2'($urandom_range(2)), 2'($urandom), 5'($urandom), 5'($urandom),
          3'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    idle();
    repeat (3) @(posedge clk);
    apb(1'b0, 12'h008, 32'h0, {31'h0, stat});
    apb(1'b1, 12'h008, 32'h3, 33'h0);
    apb(1'b0, 12'h008, 32'h0, 33'h0);
    apb(1'b0, 12'h000, 32'h0, {1'b0, 32'hD003_0000});
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule

bind vector_reg_width_alias_caps vrf_properties i_vrf_properties (
  .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .ins_valid,
  .ins_prefix, .ins_len, .ins_esize, .ins_short256_only, .ins_src_rd, .ins_mask_sel,
  .ins_rr_form, .ins_rnd_ovr, .ins_rnd_mode, .ins_disp8, .ins_disp_scale, .ins_rvalid,
  .ins_ud, .rnd_mode, .disp, .elem_en, .mk_we, .mk_idx, .mk_wdata, .mk_ridx, .mk_rdata);
